// file: dv/isp_host_model.sv
`timescale 1ns/1ns
module isp_host_model(
   input wire logic ref_clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o = 1'b0, stb_o = 1'b0, we_o = 1'b0,
   output logic [3:0] sel_o = 4'h0,
   output logic [31:0] adr_o = 32'h0000_0000, dat_o = 32'h0000_0000
);
   // Released address and data lines show the inverse of the last value.
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [7:0] r);
      @(posedge ref_clk_i);
      {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {2'b11, w, 4'h1, a, d};
      do @(posedge ref_clk_i); while (!ack_i);
      r = dat_i[7:0];
      {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} <= {7'h00, ~a, ~d};
   endtask : xfer
endmodule : isp_host_model

// file: dv/isp_irq_port_monitor.sv
`timescale 1ns/1ns
module isp_irq_port_monitor(
   input wire logic ref_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [31:0] wb_adr_i, wb_dat_o,
   input wire logic irq_pin_o, irq_pin_oe_n_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // ==========
   // Bus answer and pin checks.
   a_ack_on_req: assert property (req |=> wb_ack_o)
      else $error("no ack");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("long ack");
   a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("stray ack");
   a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("data not zero");
   a_upper_bytes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper bytes set");
   a_unmapped_reads_zero: assert property
      (req && !wb_we_i && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read");
   a_reset_pin_low: assert property
      ($rose(rst_n_i) |-> !irq_pin_o && !irq_pin_oe_n_o) else $error("pin after reset");
   a_reset_ack_low: assert property ($rose(rst_n_i) |-> !wb_ack_o)
      else $error("ack after reset");
   c_write: cover property (req && wb_we_i);
   c_read: cover property (req && !wb_we_i);
   c_pin_high: cover property (irq_pin_o);
endmodule : isp_irq_port_monitor
bind isp_irq_port isp_irq_port_monitor u_mon(.ref_clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_dat_o, .irq_pin_o, .irq_pin_oe_n_o);

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0, idle = 1'b0;
   logic [6:0] ev = 7'h00;
   logic [5:0] tm = 6'h00;
   logic [4:0] er = 5'h00;
   logic cyc, stb, we, ack, pin, oe_n;
   logic [3:0] sel;
   logic [31:0] adr, wd, rd;
   logic [7:0] r, s, b;
   int num_errors = 0, compares = 0, cyc_n = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   isp_host_model host(.ref_clk_i, .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wd));
   isp_irq_port DUT(.ref_clk_i, .rst_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .high_level_warning_i(ev[6]), .low_level_warning_i(ev[5]), .cmd_self_end_i(ev[4]),
      .host_idle_cmd_i(idle), .tx_last_bit_i(ev[3]), .rx_stream_end_i(ev[2]),
      .buffer_write_violation_i(er[0]), .buffer_overflow_error_i(er[1]),
      .protocol_violation_i(er[2]), .empty_data_error_i(er[3]), .integrity_error_i(er[4]),
      .frame_start_i(ev[0]), .card_found_i(tm[5]), .timer_underflow_i(tm[4:0]),
      .irq_pin_o(pin), .irq_pin_oe_n_o(oe_n));
   function automatic logic [7:0] upd(input logic [7:0] q, v);
      return {1'b0, v[7] ? q[6:0] | v[6:0] : q[6:0] & ~v[6:0]};
   endfunction : upd
   task chk(input string n, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h seen %h", n, exp, seen);
      end
   endtask : chk
   task wr(input logic [31:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, {24'h00_0000, d}, r);
   endtask : wr
   task rdc(input string n, input logic [31:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 32'h0000_0000, r);
      chk(n, r, e);
   endtask : rdc
   task pulse(input logic [6:0] v, input logic [5:0] t, input logic [4:0] e);
      @(posedge ref_clk_i);
      {ev, tm, er} <= {v, t, e};
      @(posedge ref_clk_i);
      {ev, tm, er} <= 18'h0_0000;
   endtask : pulse
   task pc(input string n, input logic [1:0] e);
      repeat (3) @(posedge ref_clk_i);
      chk(n, {pin, oe_n}, e);
   endtask : pc
   task stop_test;
      if (num_errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   always @(posedge ref_clk_i) if (++cyc_n == 4000) begin
      num_errors++;
      stop_test;
   end
   initial begin
      void'($urandom(29));
      repeat (12) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rdc("stat_lo", 32'h18, 8'h00);
      wr(32'h18, 8'hFF);
      rdc("set_all", 32'h18, 8'h7F);
      wr(32'h1C, 8'hFF);
      rdc("hi_set", 32'h1C, 8'h3F);
      s = 8'h7F;
      repeat (8) begin
         b = $urandom;
         s = upd(s, b);
         wr(32'h18, b);
         rdc("rand_sc", 32'h18, s);
      end
      for (int i = 0; i < 7; i++) begin
         wr(32'h18, 8'h7F);
         if (i == 1) pulse(7'h00, 6'h00, 5'h01 << ($urandom % 5));
         else pulse(7'h01 << i, 6'h00, 5'h00);
         rdc("low_evt", 32'h18, 8'h01 << i);
      end
      wr(32'h18, 8'h7F);
      idle <= 1'b1;
      pulse(7'h10, 6'h00, 5'h00);
      idle <= 1'b0;
      rdc("host_idle", 32'h18, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(32'h1C, 8'h7F);
         pulse(7'h00, 6'h01 << i, 5'h00);
         rdc("hi_evt", 32'h1C, 8'h01 << i);
      end
      wr(32'h1C, 8'h7F);
      wr(32'h24, 8'hC0);
      wr(32'h20, 8'h01);
      wr(32'h18, 8'h81);
      pc("pin_on", 2'b10);
      rdc("combined", 32'h1C, 8'h40);
      wr(32'h20, 8'h81);
      pc("pin_inv", 2'b00);
      wr(32'h20, 8'h01);
      wr(32'h24, 8'h80);
      pc("gate_off", 2'b00);
      wr(32'h24, 8'hC0);
      wr(32'h20, 8'h00);
      pc("masked", 2'b00);
      rdc("still_set", 32'h18, 8'h01);
      fork
         wr(32'h18, 8'h01);
         pulse(7'h01, 6'h00, 5'h00);
      join
      rdc("set_wins", 32'h18, 8'h01);
      wr(32'h20, 8'h01);
      wr(32'h24, 8'h40);
      pc("open_drain", 2'b11);
      b = $urandom;
      wr(32'h14, b);
      wr(32'h14, ~b);
      rdc("level", 32'h10, 8'h02);
      rdc("fifo_out", 32'h14, b);
      rdc("pointer", 32'h7C, 8'h05);
      rdc("level_dn", 32'h10, 8'h01);
      rdc("unmapped", 32'h11, 8'h00);
      stop_test;
   end
endmodule : testbench

// file: src/isp_irq_port.sv
`timescale 1ns/1ns
module isp_irq_port
   import isp_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Event sources.
   input wire logic high_level_warning_i,
   input wire logic low_level_warning_i,
   input wire logic cmd_self_end_i,
   input wire logic host_idle_cmd_i,
   input wire logic tx_last_bit_i,
   input wire logic rx_stream_end_i,
   input wire logic buffer_write_violation_i,
   input wire logic buffer_overflow_error_i,
   input wire logic protocol_violation_i,
   input wire logic empty_data_error_i,
   input wire logic integrity_error_i,
   input wire logic frame_start_i,
   input wire logic card_found_i,
   input wire logic [4:0] timer_underflow_i,
   // Interrupt pin.
   output logic irq_pin_o,
   output logic irq_pin_oe_n_o
);

   // ==========================================================
   // State.
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [6:0] stat_lo;
      logic [5:0] stat_hi;
      logic [7:0] mask_lo;
      logic [7:0] mask_hi;
      logic [4:0] pointer;
      logic [ISP_AW-1:0] wr_ptr;
      logic [ISP_AW-1:0] rd_ptr;
      logic [ISP_CW-1:0] count;
      logic hi_prev;
      logic lo_prev;
      logic err_prev;
      logic pin;
      logic pin_oe_n;
   } isp_state_t;

   isp_state_t st_q;
   isp_state_t st_d;
   logic [7:0] mem_q [ISP_DEPTH];

   // ==========================================================
   // Helpers.
   function automatic logic [6:0] isp_set_clear(input logic [6:0] flags,
                                                input logic [7:0] wdat,
                                                input logic [6:0] wmask,
                                                input logic [6:0] hw);
      logic [6:0] sel;
      sel = wdat[6:0] & wmask;
      if (wdat[ISP_SET_BIT]) begin
         isp_set_clear = flags | sel | hw;
      end else begin
         isp_set_clear = (flags & ~sel) | hw;
      end
   endfunction : isp_set_clear

   logic req;
   logic wr;
   logic rd;
   logic lane0;
   logic [4:0] idx;
   logic mapped;
   logic err_any;
   logic [6:0] hw_lo;
   logic [6:0] hw_hi;
   logic combined;
   logic push;
   logic pop;
   logic level;

   // ==========================================================
   // Bus handshake.
   // A request that is already acknowledged is not taken a second time.
   assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;
   assign wr = req & wb_we_i;
   assign rd = req & ~wb_we_i;
   assign lane0 = wb_sel_i[0];
   assign idx = wb_adr_i[6:2];
   assign mapped = (wb_adr_i[31:7] == 25'h000_0000) & (wb_adr_i[1:0] == 2'b00);

   // ==========================================================
   // Register decode and read helpers.
   function automatic logic isp_hit(input logic [4:0] a, input logic [4:0] target);
      isp_hit = (a == target);
   endfunction : isp_hit

   function automatic logic [31:0] isp_pad_byte(input logic [7:0] v);
      isp_pad_byte = {24'h00_0000, v};
   endfunction : isp_pad_byte

   function automatic logic [31:0] isp_pad_count(input logic [ISP_CW-1:0] c);
      isp_pad_count = {{(32-ISP_CW){1'b0}}, c};
   endfunction : isp_pad_count

   function automatic logic [ISP_AW-1:0] isp_ptr_step(input logic [ISP_AW-1:0] p);
      // The pointers are as wide as the buffer address, so they wrap by themselves.
      isp_ptr_step = p + ISP_AW'(1);
   endfunction : isp_ptr_step

   function automatic logic [ISP_CW-1:0] isp_next_count(input logic [ISP_CW-1:0] c,
                                                        input logic up,
                                                        input logic down);
      logic [ISP_CW-1:0] n;
      n = c;
      if (up & ~down) begin
         n = c + ISP_CW'(1);
      end else if (down & ~up) begin
         n = c - ISP_CW'(1);
      end
      isp_next_count = n;
   endfunction : isp_next_count

   function automatic logic [31:0] isp_read_word(input logic [4:0] a,
                                                 input logic [ISP_CW-1:0] count,
                                                 input logic [7:0] head,
                                                 input logic [6:0] flags_lo,
                                                 input logic [5:0] flags_hi,
                                                 input logic live,
                                                 input logic [7:0] enab_lo,
                                                 input logic [7:0] enab_hi,
                                                 input logic [4:0] ptr);
      logic [31:0] w;
      w = ISP_WORD_RESET;
      unique case (a)
         ISP_IDX_LEVEL: begin
            w = isp_pad_count(count);
         end
         ISP_IDX_DATA: begin
            w = isp_pad_byte(head);
         end
         ISP_IDX_STAT_LO: begin
            w = isp_pad_byte({1'b0, flags_lo});
         end
         ISP_IDX_STAT_HI: begin
            // The combined request is live and has no latch of its own.
            w = isp_pad_byte({1'b0, live, flags_hi});
         end
         ISP_IDX_MASK_LO: begin
            w = isp_pad_byte(enab_lo);
         end
         ISP_IDX_MASK_HI: begin
            w = isp_pad_byte(enab_hi);
         end
         ISP_IDX_POINTER: begin
            w = isp_pad_byte({3'b000, ptr});
         end
         default: begin
            w = ISP_WORD_RESET;
         end
      endcase
      isp_read_word = w;
   endfunction : isp_read_word

   logic wr_byte;
   logic hit_data;
   logic hit_stat_lo;
   logic hit_stat_hi;
   logic hit_mask_lo;
   logic hit_mask_hi;
   logic wr_stat_lo;
   logic wr_stat_hi;
   logic wr_mask_lo;
   logic wr_mask_hi;
   logic buf_full;
   logic buf_empty;

   // Writes act on byte lane zero only; the other lanes carry no register bits.
   assign wr_byte = wr & lane0 & mapped;
   assign hit_data = mapped & isp_hit(idx, ISP_IDX_DATA);
   assign hit_stat_lo = mapped & isp_hit(idx, ISP_IDX_STAT_LO);
   assign hit_stat_hi = mapped & isp_hit(idx, ISP_IDX_STAT_HI);
   assign hit_mask_lo = mapped & isp_hit(idx, ISP_IDX_MASK_LO);
   assign hit_mask_hi = mapped & isp_hit(idx, ISP_IDX_MASK_HI);

   assign wr_stat_lo = wr_byte & hit_stat_lo;
   assign wr_stat_hi = wr_byte & hit_stat_hi;
   assign wr_mask_lo = wr_byte & hit_mask_lo;
   assign wr_mask_hi = wr_byte & hit_mask_hi;

   assign buf_full = (st_q.count == ISP_FULL_COUNT);
   assign buf_empty = (st_q.count == ISP_EMPTY_COUNT);

   // ==========================================================
   // Event capture.
   logic hi_rise;
   logic lo_rise;
   logic cmd_end;
   logic err_rise;
   logic [6:0] stat_lo_wr;
   logic [6:0] stat_hi_wr;
   logic [6:0] enabled_lo;
   logic [5:0] enabled_hi;
   logic [7:0] buf_head;

   // The warnings are live levels; only their rising edge is a new event.
   assign hi_rise = high_level_warning_i & ~st_q.hi_prev;
   assign lo_rise = low_level_warning_i & ~st_q.lo_prev;

   // An end caused by the host's own idle command is not reported.
   assign cmd_end = cmd_self_end_i & ~host_idle_cmd_i;

   // The five error sources are levels; the summary flags an error raised while no other is.
   assign err_any = buffer_write_violation_i |
                    buffer_overflow_error_i |
                    protocol_violation_i |
                    empty_data_error_i |
                    integrity_error_i;
   assign err_rise = err_any & ~st_q.err_prev;

   assign hw_lo = {hi_rise,
                   lo_rise,
                   cmd_end,
                   tx_last_bit_i,
                   rx_stream_end_i,
                   err_rise,
                   frame_start_i};
   assign hw_hi = {1'b0,
                   card_found_i,
                   timer_underflow_i};

   // ==========================================================
   // Set and clear writes; an event in the same cycle wins over a clear.
   assign stat_lo_wr = isp_set_clear(st_q.stat_lo,
                                     wb_dat_i[7:0],
                                     ISP_LO_WMASK,
                                     hw_lo);
   assign stat_hi_wr = isp_set_clear({1'b0, st_q.stat_hi},
                                     wb_dat_i[7:0],
                                     ISP_HI_WMASK,
                                     hw_hi);

   // ==========================================================
   // Combined request.
   assign enabled_lo = st_q.stat_lo & st_q.mask_lo[6:0];
   assign enabled_hi = st_q.stat_hi & st_q.mask_hi[5:0];
   assign combined = (|enabled_lo) | (|enabled_hi);

   // ==========================================================
   // Buffer handshake.
   // A full buffer drops the byte and an empty one answers zero.
   assign push = wr_byte & hit_data & ~buf_full;
   assign pop = rd & hit_data & ~buf_empty;
   assign buf_head = pop ? mem_q[st_q.rd_ptr] : ISP_BYTE_RESET;

   // ==========================================================
   // Next state.
   always_comb begin
      st_d = st_q;
      level = 1'b0;
      // One acknowledge per taken request; it falls again in the next cycle.
      st_d.ack = req;
      // Edge detector history.
      st_d.hi_prev = high_level_warning_i;
      st_d.lo_prev = low_level_warning_i;
      st_d.err_prev = err_any;
      // Flags stay latched; hardware events are added every cycle.
      st_d.stat_lo = st_q.stat_lo | hw_lo;
      st_d.stat_hi = st_q.stat_hi | hw_hi[5:0];
      if (wr_stat_lo) begin
         st_d.stat_lo = stat_lo_wr;
      end
      if (wr_stat_hi) begin
         st_d.stat_hi = stat_hi_wr[5:0];
      end
      if (wr_mask_lo) begin
         st_d.mask_lo = wb_dat_i[7:0];
      end
      if (wr_mask_hi) begin
         st_d.mask_hi = wb_dat_i[7:0];
      end
      // Buffer pointers and byte count.
      if (push) begin
         st_d.wr_ptr = isp_ptr_step(st_q.wr_ptr);
      end
      if (pop) begin
         st_d.rd_ptr = isp_ptr_step(st_q.rd_ptr);
      end
      st_d.count = isp_next_count(st_q.count, push, pop);
      // The register pointer follows every mapped access except those to the data port.
      if (req & mapped & ~hit_data) begin
         st_d.pointer = idx + ISP_PTR_STEP;
      end
      // Read data stands for the acknowledge cycle only.
      st_d.rdat = ISP_WORD_RESET;
      if (rd & mapped) begin
         st_d.rdat = isp_read_word(idx,
                                   st_q.count,
                                   buf_head,
                                   st_q.stat_lo,
                                   st_q.stat_hi,
                                   combined,
                                   st_q.mask_lo,
                                   st_q.mask_hi,
                                   st_q.pointer);
      end
      // Interrupt pin.
      level = combined & st_q.mask_hi[ISP_GATE_BIT];
      level = level ^ st_q.mask_lo[ISP_MASK_INV_BIT];
      st_d.pin = level;
      if (st_q.mask_hi[ISP_DRIVE_BIT]) begin
         st_d.pin_oe_n = 1'b0;
      end else begin
         // Open drain: drive a low level, release the pin for a high one.
         st_d.pin_oe_n = level;
      end
   end

   // ==========================================================
   // State registers.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Buffer storage; it has no reset, so a byte is unknown until written.
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_q[st_q.wr_ptr] <= wb_dat_i[7:0];
      end
   end

   // ==========================================================
   // Outputs.
   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.rdat;
   assign irq_pin_o = st_q.pin;
   assign irq_pin_oe_n_o = st_q.pin_oe_n;

endmodule : isp_irq_port

// file: src/isp_pkg.sv
package isp_pkg;

   // ==========================================================
   // Register indices; the byte address is four times the index.
   localparam logic [4:0] ISP_IDX_LEVEL = 5'h04;
   localparam logic [4:0] ISP_IDX_DATA = 5'h05;
   localparam logic [4:0] ISP_IDX_STAT_LO = 5'h06;
   localparam logic [4:0] ISP_IDX_STAT_HI = 5'h07;
   localparam logic [4:0] ISP_IDX_MASK_LO = 5'h08;
   localparam logic [4:0] ISP_IDX_MASK_HI = 5'h09;
   localparam logic [4:0] ISP_IDX_POINTER = 5'h1F;

   // ==========================================================
   // Field positions.
   localparam int ISP_SET_BIT = 7;
   localparam int ISP_COMBINED_BIT = 6;
   localparam int ISP_MASK_INV_BIT = 7;
   localparam int ISP_GATE_BIT = 6;
   localparam int ISP_DRIVE_BIT = 7;

   // ==========================================================
   // Buffer geometry and reset values.
   localparam int ISP_DEPTH = 512;
   localparam int ISP_AW = 9;
   localparam int ISP_CW = 10;
   localparam logic [ISP_CW-1:0] ISP_FULL_COUNT = 10'h200;
   localparam logic [ISP_CW-1:0] ISP_EMPTY_COUNT = 10'h000;
   localparam logic [6:0] ISP_LO_WMASK = 7'h7F;
   localparam logic [6:0] ISP_HI_WMASK = 7'h3F;
   localparam logic [4:0] ISP_PTR_STEP = 5'h01;
   localparam logic [7:0] ISP_BYTE_RESET = 8'h00;
   localparam logic [31:0] ISP_WORD_RESET = 32'h0000_0000;

endpackage : isp_pkg
